// ### shared/usb_ctrl_pkg.sv
// constants, states and carriers of the control-endpoint event logic
// assumes one 25 MHz clock and a byte-wide command port from the master
package usb_ctrl_pkg;
	// command byte layout
	localparam int CMD_ADDR_BIT = 7; // 1 marks an address byte
	localparam int CMD_RW_BIT = 6; // 1 marks a register read
	localparam int NIB_W = 4; // data bytes carry one nibble
	// register addresses
	localparam logic [5:0] ADDR_EMPTY = 6'h30; // out_pair_empty_status
	localparam logic [5:0] ADDR_COMMIT = 6'h31; // in_packet_commit
	localparam logic [5:0] ADDR_STALL = 6'h32; // control_request_stall
	localparam logic [7:0] STALL_RESET = 8'h00;
	// endpoints a commit may name
	localparam logic [3:0] EP_IN_A = 4'h6;
	localparam logic [3:0] EP_IN_B = 4'h8;
	// event source codes handed to the master
	localparam logic [7:0] CODE_SETUP = 8'h01;
	localparam logic [7:0] CODE_CTRL_BUF = 8'h02;
	localparam logic [7:0] CODE_ENUM = 8'h04;
	localparam logic [7:0] CODE_FIFO = 8'h08;
	localparam int N_EV = 4; // event flags, lowest index wins
	// standard request fields
	localparam logic [7:0] REQ_CLEAR_FEATURE = 8'h01;
	localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
	localparam logic [1:0] TYPE_STANDARD = 2'h0;
	localparam logic [4:0] RCPT_ENDPOINT = 5'h02;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_HI = 4'h2,
		ST_LO = 4'h4,
		ST_EXEC = 4'h8
	} cmd_state_e;

	// setup packet as the usb engine presents it
	typedef struct packed {
		logic valid; // one-cycle pulse
		logic [7:0] req_type;
		logic [7:0] request;
		logic length_nz; // data stage follows
	} setup_s;

	// usb-side happenings, one-cycle pulses
	typedef struct packed {
		logic enum_done;
		logic ctrl_in_free;
		logic ctrl_out_arrived;
		logic out2_arrived;
		logic out4_arrived;
	} usb_ev_s;
endpackage : usb_ctrl_pkg

// ### src/usb_ctrl_event.sv
// control endpoint, event line and command register logic of the
// usb slave; the master writes command bytes on a strobe synchronous
// to clk and acknowledges each event byte with a read strobe
`timescale 1ns/1ps

module usb_ctrl_event (
	input wire logic clk, // 25 MHz clock
	input wire logic resetn, // asynchronous reset, active low
	input wire logic cmd_strobe, // master writes cmd_byte
	input wire logic [7:0] cmd_byte, // command address or data byte
	output logic cmd_ready, // high when a byte may be written
	input wire logic rd_ack, // master has read rd_data
	output logic [7:0] rd_data, // byte that goes with the event
	output logic master_event_n, // event line, active low
	input wire usb_ctrl_pkg::setup_s setup, // setup packet seen
	input wire usb_ctrl_pkg::usb_ev_s usb_ev, // usb-side pulses
	input wire logic ep2_empty, // out endpoint 2 holds no data
	input wire logic ep4_empty, // out endpoint 4 holds no data
	output logic std_answer, // pulse: engine answers request itself
	output logic ctrl_stall, // stall the pending control request
	output logic in_commit_valid, // pulse: commit short in packet
	output logic in_commit_ep8 // commit targets endpoint 8, else 6
);
	usb_ctrl_pkg::cmd_state_e state_q;
	logic gap_q;
	logic [5:0] addr_q;
	logic [3:0] hi_q;
	logic [7:0] wdata_q;
	logic rd_pend_q;
	logic rd_loaded_q;
	logic ev_active_q;
	logic [7:0] rd_data_q;
	logic [7:0] stall_reg_q;
	logic ctrl_stall_q;
	logic std_answer_q;
	logic commit_q;
	logic commit_ep8_q;
	logic [usb_ctrl_pkg::N_EV-1:0] ev_pend_q;
	logic [usb_ctrl_pkg::N_EV-1:0] ev_set;
	logic [usb_ctrl_pkg::N_EV-1:0] ev_clr;
	logic [7:0] reg_rdata;
	logic [7:0] ev_code;
	logic take;
	logic is_feature;
	logic is_std;
	logic is_ep_feature;
	logic ev_load;
	logic rd_start;

	// a byte is accepted only while ready; a read blocks new bytes
	assign cmd_ready = !gap_q && !rd_pend_q &&
		state_q != usb_ctrl_pkg::ST_EXEC;
	assign take = cmd_strobe && cmd_ready;
	// a read address byte opens a pending register read
	assign rd_start = take && state_q == usb_ctrl_pkg::ST_IDLE &&
		cmd_byte[usb_ctrl_pkg::CMD_ADDR_BIT] &&
		cmd_byte[usb_ctrl_pkg::CMD_RW_BIT];

	// ready drops for one cycle after every accepted byte
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gap_q <= 1'b0;
		end else begin
			gap_q <= take;
		end
	end

	// command parser: address byte, then two nibble bytes for writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= usb_ctrl_pkg::ST_IDLE;
			addr_q <= 6'h00;
			hi_q <= 4'h0;
			wdata_q <= 8'h00;
		end else begin
			case (state_q)
			usb_ctrl_pkg::ST_IDLE: begin
				// a data byte with no address before it is ignored
				if (take && cmd_byte[usb_ctrl_pkg::CMD_ADDR_BIT]) begin
					addr_q <= cmd_byte[5:0];
					if (!cmd_byte[usb_ctrl_pkg::CMD_RW_BIT]) begin
						state_q <= usb_ctrl_pkg::ST_HI;
					end
				end
			end
			usb_ctrl_pkg::ST_HI: begin
				if (take) begin
					hi_q <= cmd_byte[usb_ctrl_pkg::NIB_W-1:0];
					state_q <= usb_ctrl_pkg::ST_LO;
				end
			end
			usb_ctrl_pkg::ST_LO: begin
				if (take) begin
					wdata_q <= {hi_q, cmd_byte[usb_ctrl_pkg::NIB_W-1:0]};
					state_q <= usb_ctrl_pkg::ST_EXEC;
				end
			end
			usb_ctrl_pkg::ST_EXEC: begin
				state_q <= usb_ctrl_pkg::ST_IDLE;
			end
			default: begin
				state_q <= usb_ctrl_pkg::ST_IDLE;
			end
			endcase
		end
	end

	// request classification for the setup packet
	assign is_std = setup.req_type[6:5] == usb_ctrl_pkg::TYPE_STANDARD;
	assign is_feature = setup.request == usb_ctrl_pkg::REQ_SET_FEATURE ||
		setup.request == usb_ctrl_pkg::REQ_CLEAR_FEATURE;
	assign is_ep_feature = is_std && is_feature &&
		setup.req_type[4:0] == usb_ctrl_pkg::RCPT_ENDPOINT;

	// standard requests are answered here; endpoint features are not
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			std_answer_q <= 1'b0;
		end else begin
			std_answer_q <= setup.valid && is_std && !is_ep_feature;
		end
	end
	assign std_answer = std_answer_q;

	// stall register: nonzero write stalls the pending request; a new
	// setup packet starts clean, except that a stall write executing in the same cycle wins and hits it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stall_reg_q <= usb_ctrl_pkg::STALL_RESET;
			ctrl_stall_q <= 1'b0;
		end else if (state_q == usb_ctrl_pkg::ST_EXEC &&
			addr_q == usb_ctrl_pkg::ADDR_STALL) begin
			stall_reg_q <= wdata_q;
			ctrl_stall_q <= wdata_q != 8'h00;
		end else if (setup.valid) begin
			ctrl_stall_q <= 1'b0;
		end
	end
	assign ctrl_stall = ctrl_stall_q;

	// commit of a short in packet on endpoint 6 or 8
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			commit_q <= 1'b0;
			commit_ep8_q <= 1'b0;
		end else begin
			commit_q <= 1'b0;
			if (state_q == usb_ctrl_pkg::ST_EXEC &&
				addr_q == usb_ctrl_pkg::ADDR_COMMIT &&
				(wdata_q[3:0] == usb_ctrl_pkg::EP_IN_A ||
				wdata_q[3:0] == usb_ctrl_pkg::EP_IN_B)) begin
				commit_q <= 1'b1;
				commit_ep8_q <= wdata_q[3:0] == usb_ctrl_pkg::EP_IN_B;
			end
		end
	end
	assign in_commit_valid = commit_q;
	assign in_commit_ep8 = commit_ep8_q;

	// register read mux; unmapped addresses read as zero
	always_comb begin
		case (addr_q)
		usb_ctrl_pkg::ADDR_EMPTY: begin
			reg_rdata = {6'h00, ep4_empty, ep2_empty};
		end
		usb_ctrl_pkg::ADDR_STALL: reg_rdata = stall_reg_q;
		default: reg_rdata = 8'h00;
		endcase
	end

	// event sources: setup, control buffer, enumeration, fifo data
	assign ev_set[0] = setup.valid && (is_feature || !is_std);
	assign ev_set[1] = (setup.valid && setup.length_nz) ||
		usb_ev.ctrl_in_free ||
		usb_ev.ctrl_out_arrived;
	assign ev_set[2] = usb_ev.enum_done;
	assign ev_set[3] = usb_ev.out2_arrived || usb_ev.out4_arrived;

	// pick the lowest pending flag when the line is free
	always_comb begin
		ev_clr = '0;
		ev_code = 8'h00;
		if (ev_pend_q[0]) begin
			ev_clr[0] = 1'b1;
			ev_code = usb_ctrl_pkg::CODE_SETUP;
		end else if (ev_pend_q[1]) begin
			ev_clr[1] = 1'b1;
			ev_code = usb_ctrl_pkg::CODE_CTRL_BUF;
		end else if (ev_pend_q[2]) begin
			ev_clr[2] = 1'b1;
			ev_code = usb_ctrl_pkg::CODE_ENUM;
		end else if (ev_pend_q[3]) begin
			ev_clr[3] = 1'b1;
			ev_code = usb_ctrl_pkg::CODE_FIFO;
		end
	end
	// a pending register read outranks queued events; an event is also
	// held back in the cycle a read opens, else the master would take
	// the event code for the register byte it asked for
	assign ev_load = !ev_active_q && !rd_start &&
		!(rd_pend_q && !rd_loaded_q) && ev_pend_q != '0;

	// sticky event flags; a new event in the clearing cycle survives
	generate
		for (genvar i = 0; i < usb_ctrl_pkg::N_EV; i++) begin : g_ev
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					ev_pend_q[i] <= 1'b0;
				end else begin
					ev_pend_q[i] <= (ev_pend_q[i] && !(ev_load && ev_clr[i])) ||
						ev_set[i];
				end
			end
		end
	endgenerate

	// pending read flag: set by a read address byte, cleared on ack
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_pend_q <= 1'b0;
			rd_loaded_q <= 1'b0;
		end else if (rd_start) begin
			rd_pend_q <= 1'b1;
			rd_loaded_q <= 1'b0;
		end else if (rd_pend_q && !rd_loaded_q && !ev_active_q) begin
			rd_loaded_q <= 1'b1;
		end else if (rd_loaded_q && ev_active_q && rd_ack) begin
			rd_pend_q <= 1'b0;
			rd_loaded_q <= 1'b0;
		end
	end

	// event line with its byte; the byte is loaded with the line so
	// the master never sees the line low over stale data
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ev_active_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else if (ev_active_q) begin
			if (rd_ack) begin
				ev_active_q <= 1'b0;
			end
		end else if (rd_pend_q && !rd_loaded_q) begin
			ev_active_q <= 1'b1;
			rd_data_q <= reg_rdata;
		end else if (ev_load) begin
			ev_active_q <= 1'b1;
			rd_data_q <= ev_code;
		end
	end
	assign master_event_n = !ev_active_q;
	assign rd_data = rd_data_q;

	ready_gap_a: assert property (@(posedge clk) disable iff (!resetn)
		take |=> !cmd_ready)
		else $error("ready stayed high after a byte");
	event_release_a: assert property (@(posedge clk) disable iff (!resetn)
		!master_event_n && rd_ack |=> master_event_n)
		else $error("event line not released after read");
	event_byte_a: assert property (@(posedge clk) disable iff (!resetn)
		!master_event_n && !rd_ack |=> $stable(rd_data) && !master_event_n)
		else $error("event byte changed while line low");
	stall_write_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == usb_ctrl_pkg::ST_EXEC && addr_q == usb_ctrl_pkg::ADDR_STALL
		|=> ctrl_stall == ($past(wdata_q) != 8'h00))
		else $error("stall does not follow register write");
	commit_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
		state_q == usb_ctrl_pkg::ST_EXEC && addr_q == usb_ctrl_pkg::ADDR_COMMIT &&
		wdata_q[3:0] == usb_ctrl_pkg::EP_IN_A |=> in_commit_valid && !in_commit_ep8)
		else $error("commit of endpoint 6 missing");
	std_auto_a: assert property (@(posedge clk) disable iff (!resetn)
		setup.valid && is_ep_feature |=> !std_answer)
		else $error("endpoint feature answered locally");
	feature_event_a: assert property (@(posedge clk) disable iff (!resetn)
		setup.valid && is_feature |=> ev_pend_q[0] ||
		(!master_event_n && rd_data == usb_ctrl_pkg::CODE_SETUP))
		else $error("feature request raised no event");
	ctrl_buf_a: assert property (@(posedge clk) disable iff (!resetn)
		setup.valid && setup.length_nz |=> ev_pend_q[1] ||
		(!master_event_n && rd_data == usb_ctrl_pkg::CODE_CTRL_BUF))
		else $error("data stage raised no buffer event");
	read_event_a: assert property (@(posedge clk) disable iff (!resetn)
		take && state_q == usb_ctrl_pkg::ST_IDLE && cmd_byte[7:6] == 2'h3
		|-> ##[1:300] (!master_event_n && rd_loaded_q))
		else $error("register read never signalled");
	fifo_event_a: assert property (@(posedge clk) disable iff (!resetn)
		usb_ev.out2_arrived |=> ev_pend_q[3] ||
		(!master_event_n && rd_data == usb_ctrl_pkg::CODE_FIFO))
		else $error("fifo arrival raised no event");
endmodule : usb_ctrl_event

// ### verification/master_model.sv
// external master model: writes command bytes and takes event bytes
// assumes design outputs settle within 1 ns of the clock edge
`timescale 1ns/1ps
module master_model (
	input wire logic clk, // 25 MHz clock
	input wire logic cmd_ready, // device takes a byte
	input wire logic [7:0] rd_data, // byte that goes with the event
	input wire logic master_event_n, // event line, active low
	output logic cmd_strobe, // byte strobe
	output logic [7:0] cmd_byte, // command byte
	output logic rd_ack, // event byte taken
	output logic got, // pulse: a byte was taken
	output logic [7:0] got_byte, // the byte taken
	output logic hung // ready never came back
);
	// bounded poll, a stuck ready flags the bench
	task automatic wait_rdy();
		int k;
		for (k = 0; k < 64 && cmd_ready !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (k == 64) hung = 1'b1;
	endtask : wait_rdy

	// one byte, begun only while ready is high
	task automatic put(input logic [7:0] b);
		wait_rdy();
		cmd_strobe = 1'b1;
		cmd_byte = b;
		@(posedge clk);
		#1;
		cmd_strobe = 1'b0;
		cmd_byte = ~b; // a stale byte must not look valid
	endtask : put

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		put({2'b10, a});
		put({4'h0, d[7:4]});
		put({4'h0, d[3:0]});
		wait_rdy();
	endtask : wr

	task automatic rd(input logic [5:0] a);
		put({2'b11, a});
	endtask : rd

	// takes each event byte after a random delay, fast or slow
	initial begin
		cmd_strobe = 1'b0;
		cmd_byte = 8'h00;
		rd_ack = 1'b0;
		got = 1'b0;
		got_byte = 8'h00;
		hung = 1'b0;
		forever begin
			@(posedge clk);
			#1;
			if (master_event_n === 1'b0) begin
				repeat ($urandom_range(3)) begin
					@(posedge clk);
					#1;
				end
				rd_ack = 1'b1;
				got_byte = rd_data;
				got = 1'b1;
				@(posedge clk);
				#1;
				rd_ack = 1'b0;
				got = 1'b0;
			end
		end
	end
endmodule : master_model

// ### verification/usb_ctrl_event_tb.sv
// self-checking bench of the control-endpoint event logic
// assumes the master model takes every event byte
`timescale 1ns/1ps
module usb_ctrl_event_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cmd_strobe, rd_ack, cmd_ready, master_event_n, got, hung;
	logic [7:0] cmd_byte, rd_data, got_byte, v;
	logic ep2_empty = 1'b1;
	logic ep4_empty = 1'b1;
	logic std_answer, ctrl_stall, in_commit_valid, in_commit_ep8, last_ep8;
	usb_ctrl_pkg::setup_s setup = '0;
	usb_ctrl_pkg::usb_ev_s usb_ev = '0;
	logic [7:0] q[$];
	int n_errors = 0;
	int compares = 0;
	int n_commit = 0;
	int i;
	int n_lb;
	// req_type, request, 6'h0, length_nz, local answer, event code
	logic [31:0] tbl [7] = '{32'h0203_0001, 32'h0201_0001, 32'h0001_0101,
		32'h8006_0302, 32'h40AA_0001, 32'h4042_0001, 32'h40B6_0001};
	logic [7:0] evc [5] = '{8'h04, 8'h02, 8'h02, 8'h08, 8'h08};
	logic [7:0] cv [3] = '{8'h06, 8'h08, 8'h05};

	always #20 clk = ~clk;

	usb_ctrl_event usb_ctrl_event_i (.clk(clk), .resetn(resetn),
		.cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte), .cmd_ready(cmd_ready),
		.rd_ack(rd_ack), .rd_data(rd_data), .master_event_n(master_event_n),
		.setup(setup), .usb_ev(usb_ev), .ep2_empty(ep2_empty),
		.ep4_empty(ep4_empty), .std_answer(std_answer),
		.ctrl_stall(ctrl_stall), .in_commit_valid(in_commit_valid),
		.in_commit_ep8(in_commit_ep8));
	master_model master_model_i (.clk(clk), .cmd_ready(cmd_ready),
		.rd_data(rd_data), .master_event_n(master_event_n),
		.cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte), .rd_ack(rd_ack),
		.got(got), .got_byte(got_byte), .hung(hung));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	// bounded wait until every noted byte came and the line is idle
	task automatic drain();
		for (i = 0; i < 300 && (q.size() != 0 || master_event_n !== 1'b1);
			i++) tick();
		if (i == 300) begin
			n_errors++;
			wrap_up();
		end
	endtask : drain

	// master side of a handed-over request: endpoint features go to the
	// endpoint's own stall, 0xAA and 0xAB pass, 0xB6 and 0xB8 commit a
	// short in packet, any other class or vendor request is stalled
	task automatic serve(input logic [15:0] rr);
		logic [7:0] ep;
		ep = (rr[7:0] == 8'hB6) ? 8'h06 : 8'h08;
		if (rr[15:8] == 8'h02) begin
			chk({7'h0, ctrl_stall}, 8'h00);
		end else if (rr == 16'h40AA || rr == 16'h40AB) begin
			chk({7'h0, ctrl_stall}, 8'h00);
		end else if (rr == 16'h40B6 || rr == 16'h40B8) begin
			chk({7'h0, ctrl_stall}, 8'h00);
			n_commit = 0;
			master_model_i.wr(usb_ctrl_pkg::ADDR_COMMIT, ep);
			tick();
			chk(8'(n_commit), 8'h01);
			chk({7'h0, last_ep8}, {7'h0, ep == 8'h08});
		end else if (rr[14:13] != 2'h0) begin
			master_model_i.wr(usb_ctrl_pkg::ADDR_STALL, 8'h01);
			chk({7'h0, ctrl_stall}, 8'h01);
		end
	endtask : serve

	// an event byte nobody noted fails against its own inverse
	always @(posedge clk) begin
		if (got === 1'b1) begin
			if (q.size() == 0) chk(got_byte, ~got_byte);
			else chk(got_byte, q.pop_front());
		end
		if (in_commit_valid === 1'b1) begin
			n_commit++;
			last_ep8 = in_commit_ep8;
		end
	end

	always @(posedge hung) begin
		n_errors++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'hA0D08EA2));
		repeat (16) @(posedge clk);
		#1;
		resetn = 1'b1;
		chk({5'h0, cmd_ready, master_event_n, ctrl_stall}, 8'h06);
		// configuration is loaded before the host can enumerate
		master_model_i.wr(usb_ctrl_pkg::ADDR_STALL, 8'h00);
		q.push_back(8'h00);
		master_model_i.rd(usb_ctrl_pkg::ADDR_STALL);
		drain();
		// each request kind: local answer or hand-over to the master
		for (int k = 0; k < 7; k++) begin
			q.push_back(tbl[k][7:0]);
			setup = {1'b1, tbl[k][31:16], tbl[k][9]};
			tick();
			setup.valid = 1'b0;
			chk({7'h0, std_answer}, {7'h0, tbl[k][8]});
			drain();
			serve(tbl[k][31:16]);
		end
		// stall with a random nonzero value, read it back, then zero
		v = 8'h01 + 8'($urandom_range(254));
		master_model_i.wr(usb_ctrl_pkg::ADDR_STALL, v);
		chk({7'h0, ctrl_stall}, 8'h01);
		q.push_back(v);
		master_model_i.rd(usb_ctrl_pkg::ADDR_STALL);
		drain();
		setup = {1'b1, 8'h80, 8'h06, 1'b0};
		tick();
		setup.valid = 1'b0;
		tick();
		chk({7'h0, ctrl_stall}, 8'h00);
		master_model_i.wr(usb_ctrl_pkg::ADDR_STALL, 8'h00);
		chk({7'h0, ctrl_stall}, 8'h00);
		// every usb-side happening alone, then two at once
		for (int k = 0; k < 5; k++) begin
			q.push_back(evc[k]);
			usb_ev = 5'(5'h10 >> k);
			tick();
			usb_ev = '0;
			drain();
		end
		q.push_back(8'h04);
		q.push_back(8'h08);
		usb_ev = 5'h11;
		tick();
		usb_ev = '0;
		drain();
		// empty status in all four combinations, then an unmapped read
		for (int k = 0; k < 4; k++) begin
			{ep4_empty, ep2_empty} = 2'(k);
			q.push_back(8'(k));
			master_model_i.rd(usb_ctrl_pkg::ADDR_EMPTY);
			drain();
		end
		q.push_back(8'h00);
		master_model_i.rd(6'h3F);
		drain();
		// loopback: endpoint 2 holds a random number of bytes; the master
		// polls the status after each one until the endpoint runs empty
		n_lb = 1 + $urandom_range(3);
		ep4_empty = 1'b1;
		for (int k = 0; k <= n_lb; k++) begin
			ep2_empty = (k == n_lb);
			q.push_back({6'h00, 1'b1, ep2_empty});
			master_model_i.rd(usb_ctrl_pkg::ADDR_EMPTY);
			drain();
		end
		// commits to endpoint 6 and 8; other values do nothing
		n_commit = 0;
		for (int k = 0; k < 3; k++) begin
			master_model_i.wr(usb_ctrl_pkg::ADDR_COMMIT, cv[k]);
			tick();
			chk(8'(n_commit), (k == 0) ? 8'h01 : 8'h02);
			if (k < 2) chk({7'h0, last_ep8}, 8'(k));
		end
		wrap_up();
	end
endmodule : usb_ctrl_event_tb
